// [verilog/mbcd_pkg.sv]
// Shared constants and types for the microbranch and clock datapath block.
package mbcd_pkg;

   localparam int unsigned DATA_W      = 16;
   localparam int unsigned STATUS_W    = 8;
   localparam int unsigned BRANCH_W    = 5;
   localparam int unsigned NEXT_ADDR_W = 8;
   localparam int unsigned MATCH_W     = 9;
   localparam int unsigned CLK_MHZ     = 25;

   // Cycle lengths in nanoseconds; each microcycle is split in three equal phases.
   localparam int unsigned CYC_SHORT_NS = 240;
   localparam int unsigned CYC_MED_NS   = 360;
   localparam int unsigned CYC_LONG_NS  = 480;
   localparam int unsigned PHASE_SHORT  = (CYC_SHORT_NS * CLK_MHZ + 2999) / 3000;
   localparam int unsigned PHASE_MED    = (CYC_MED_NS * CLK_MHZ + 2999) / 3000;
   localparam int unsigned PHASE_LONG   = (CYC_LONG_NS * CLK_MHZ + 2999) / 3000;
   localparam int unsigned CNT_W        = 4;

   // Destination multiplexer selections.
   localparam logic [1:0] DSEL_READ_BUS = 2'h0;
   localparam logic [1:0] DSEL_D_REG    = 2'h1;
   localparam logic [1:0] DSEL_D_SHIFT  = 2'h2;
   localparam logic [1:0] DSEL_SYS_BUS  = 2'h3;

   // Branch test field encodings, grouped by condition source.
   localparam logic [4:0] BT_NONE      = 5'h00;
   localparam logic [4:0] BT_INSTR_LO  = 5'h01;
   localparam logic [4:0] BT_INSTR_HI  = 5'h08;
   localparam logic [4:0] BT_CTRL_LO   = 5'h09;
   localparam logic [4:0] BT_CTRL_HI   = 5'h0f;
   localparam logic [4:0] BT_DECODE_LO = 5'h10;
   localparam logic [4:0] BT_DECODE_HI = 5'h17;
   localparam logic [4:0] BT_FLAG_CC   = 5'h1e;
   localparam logic [4:0] BT_FLAG_CLR  = 5'h1f;

   localparam logic [DATA_W-1:0] D_RESET = 16'h0000;

   typedef enum logic [2:0] {
      MBCD_IDLE   = 3'b000,
      MBCD_PH1    = 3'b001,
      MBCD_PH2    = 3'b010,
      MBCD_PH3    = 3'b011,
      MBCD_HALTED = 3'b100
   } mbcd_state_t;

endpackage

// [verilog/mbcd_branch.sv]
// Branch test decode and multiplexer that modifies the next-address field.
`timescale 1ns/1ps
module mbcd_branch
   import mbcd_pkg::*;
(
   input  wire logic [BRANCH_W-1:0]    branch_test_field,
   input  wire logic [NEXT_ADDR_W-1:0] next_addr_field,
   input  wire logic [DATA_W-1:0]      instr_reg,
   input  wire logic [7:0]             branch_ctrl,
   input  wire logic [7:0]             instr_decode,
   input  wire logic [7:0]             machine_flags,
   output logic      [NEXT_ADDR_W-1:0] micro_pointer_next,
   output logic                        flag_load_cc,
   output logic                        flag_clear,
   output logic                        branch_taken
);

   logic [2:0] sel;

   always_comb begin
      sel                = branch_test_field[2:0];
      branch_taken       = 1'b0;
      flag_load_cc       = 1'b0;
      flag_clear         = 1'b0;
      micro_pointer_next = next_addr_field;
      // Auxiliary decodes for the flag control logic.
      if (branch_test_field == BT_FLAG_CC) begin
         flag_load_cc = 1'b1;
      end
      if (branch_test_field == BT_FLAG_CLR) begin
         flag_clear = 1'b1;
      end
      // Source selection; instruction bits use the field minus one as index.
      if (branch_test_field >= BT_INSTR_LO && branch_test_field <= BT_INSTR_HI) begin
         branch_taken = instr_reg[3'(branch_test_field - BT_INSTR_LO)];
      end else if (branch_test_field >= BT_CTRL_LO && branch_test_field <= BT_CTRL_HI) begin
         branch_taken = branch_ctrl[sel];
      end else if (branch_test_field >= BT_DECODE_LO && branch_test_field <= BT_DECODE_HI) begin
         branch_taken = instr_decode[sel];
      end else if (branch_test_field != BT_NONE) begin
         branch_taken = machine_flags[sel];
      end
      // A taken branch ORs the condition into the low address bit.
      micro_pointer_next[0] = next_addr_field[0] | branch_taken;
   end

endmodule

// [verilog/mbcd_top.sv]
// Top of the microbranch, clock control and destination datapath slice.
`timescale 1ns/1ps

module mbcd_top
   import mbcd_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [DATA_W-1:0]      scratch_rd_n,
   input  wire logic [STATUS_W-1:0]    proc_status_reg_n,
   input  wire logic [DATA_W-1:0]      aux_rd_n,
   input  wire logic [BRANCH_W-1:0]    branch_test_field,
   input  wire logic [NEXT_ADDR_W-1:0] next_addr_field,
   input  wire logic [DATA_W-1:0]      instr_reg,
   input  wire logic [7:0]             branch_ctrl,
   input  wire logic [7:0]             instr_decode,
   input  wire logic [7:0]             machine_flags,
   input  wire logic [MATCH_W-1:0]     buffered_micro_pointer,
   input  wire logic [MATCH_W-1:0]     switch_register,
   input  wire logic                   maint_match_halt,
   input  wire logic                   clock_halt_bit,
   input  wire logic                   cycle_length_bit0,
   input  wire logic                   cycle_length_bit1,
   input  wire logic                   restart,
   input  wire logic                   continue_run,
   input  wire logic                   en_instr,
   input  wire logic                   en_addr,
   input  wire logic                   en_b,
   input  wire logic                   en_d,
   input  wire logic                   en_write_high,
   input  wire logic                   en_write_low,
   input  wire logic [1:0]             dest_sel,
   input  wire logic [DATA_W-1:0]      alu_out,
   input  wire logic [DATA_W-1:0]      sys_bus_data,
   output logic      [DATA_W-1:0]      alu_a_input,
   output logic      [DATA_W-1:0]      addr_mux_rd,
   output logic      [NEXT_ADDR_W-1:0] micro_pointer_next,
   output logic                        flag_load_cc,
   output logic                        flag_clear,
   output logic                        branch_taken,
   output logic                        match,
   output logic                        scope_sync,
   output logic                        clk_run,
   output logic                        clk_idle,
   output logic                        phase_pulse_first,
   output logic                        phase_pulse_second,
   output logic                        phase_pulse_third,
   output logic                        recycle_pulse,
   output logic                        instr_load_enable,
   output logic                        addr_load_enable,
   output logic                        b_load_enable,
   output logic                        d_load_enable,
   output logic                        write_high_byte,
   output logic                        write_low_byte,
   output logic      [DATA_W-1:0]      dest_mux,
   output logic      [DATA_W-1:0]      data_display,
   output logic      [DATA_W-1:0]      b_reg,
   output logic      [DATA_W-1:0]      d_reg,
   output logic      [DATA_W-1:0]      sys_bus_d_out
);

   logic              rst_meta_q;
   logic              rst_sync_q;
   logic              rst_ok_n;
   logic [DATA_W-1:0] read_bus;
   mbcd_state_t       state_q;
   mbcd_state_t       state_d;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic [CNT_W-1:0]  phase_len;
   logic              run_q;
   logic              run_d;
   logic              idle_q;
   logic              idle_d;
   logic              p1_q;
   logic              p1_d;
   logic              p2_q;
   logic              p2_d;
   logic              p3_q;
   logic              p3_d;
   logic              recyc_q;
   logic              recyc_d;
   logic              sync_q;
   logic              sync_d;
   logic              phase_end;
   logic [DATA_W-1:0] d_q;
   logic [DATA_W-1:0] d_d;
   logic [DATA_W-1:0] b_q;
   logic [DATA_W-1:0] b_d;

   // Reset is asserted asynchronously and released through two flip-flops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_ok_n = rst_sync_q;

   // Sources drive the wired bus active low, so the OR of the true levels is taken after inversion.
   always_comb begin
      read_bus = ~scratch_rd_n | ~aux_rd_n | {{(DATA_W-STATUS_W){1'b0}}, ~proc_status_reg_n};
   end
   assign alu_a_input  = read_bus;
   assign addr_mux_rd  = read_bus;

   mbcd_branch u_branch (
      .branch_test_field  (branch_test_field),
      .next_addr_field    (next_addr_field),
      .instr_reg          (instr_reg),
      .branch_ctrl        (branch_ctrl),
      .instr_decode       (instr_decode),
      .machine_flags      (machine_flags),
      .micro_pointer_next (micro_pointer_next),
      .flag_load_cc       (flag_load_cc),
      .flag_clear         (flag_clear),
      .branch_taken       (branch_taken)
   );

   // Match stays combinational so the clock control sees it at the very edge that ends the cycle.
   assign match = (buffered_micro_pointer == switch_register);

   // Cycle length code 3 falls back to the long cycle so every code yields a defined length.
   always_comb begin
      if ({cycle_length_bit1, cycle_length_bit0} == 2'b00) begin
         phase_len = CNT_W'(PHASE_SHORT);
      end else if ({cycle_length_bit1, cycle_length_bit0} == 2'b01) begin
         phase_len = CNT_W'(PHASE_MED);
      end else begin
         phase_len = CNT_W'(PHASE_LONG);
      end
   end

   assign phase_end = (cnt_q == phase_len - CNT_W'(1));

   // Clock control and pulse generator.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q + CNT_W'(1);
      run_d   = run_q;
      idle_d  = idle_q;
      p1_d    = 1'b0;
      p2_d    = 1'b0;
      p3_d    = 1'b0;
      recyc_d = 1'b0;
      sync_d  = 1'b0;
      case (state_q)
         MBCD_IDLE: begin
            cnt_d = '0;
            if (restart || continue_run) begin
               state_d = MBCD_PH1;
               run_d   = 1'b1;
               idle_d  = 1'b0;
               p1_d    = 1'b1;
            end
         end
         MBCD_PH1: begin
            if (phase_end) begin
               state_d = MBCD_PH2;
               cnt_d   = '0;
               p2_d    = 1'b1;
            end
         end
         MBCD_PH2: begin
            if (phase_end) begin
               state_d = MBCD_PH3;
               cnt_d   = '0;
               p3_d    = 1'b1;
            end
         end
         MBCD_PH3: begin
            if (phase_end) begin
               cnt_d  = '0;
               sync_d = match;
               if (clock_halt_bit) begin
                  state_d = MBCD_IDLE;
                  run_d   = 1'b0;
                  idle_d  = 1'b1;
               end else if (maint_match_halt && match) begin
                  state_d = MBCD_HALTED;
                  run_d   = 1'b0;
                  idle_d  = 1'b1;
               end else begin
                  state_d = MBCD_PH1;
                  recyc_d = 1'b1;
                  p1_d    = 1'b1;
               end
            end
         end
         MBCD_HALTED: begin
            cnt_d = '0;
            if (continue_run) begin
               state_d = MBCD_PH1;
               run_d   = 1'b1;
               idle_d  = 1'b0;
               p1_d    = 1'b1;
            end
         end
         default: begin
            state_d = MBCD_IDLE;
            cnt_d   = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         state_q <= MBCD_IDLE;
         cnt_q   <= '0;
         run_q   <= 1'b0;
         idle_q  <= 1'b1;
         p1_q    <= 1'b0;
         p2_q    <= 1'b0;
         p3_q    <= 1'b0;
         recyc_q <= 1'b0;
         sync_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         run_q   <= run_d;
         idle_q  <= idle_d;
         p1_q    <= p1_d;
         p2_q    <= p2_d;
         p3_q    <= p3_d;
         recyc_q <= recyc_d;
         sync_q  <= sync_d;
      end
   end

   assign clk_run            = run_q;
   assign clk_idle           = idle_q;
   assign phase_pulse_first  = p1_q;
   assign phase_pulse_second = p2_q;
   assign phase_pulse_third  = p3_q;
   assign recycle_pulse      = recyc_q;
   assign scope_sync         = sync_q;

   // Loads happen on the third phase, once the datapath has settled; writes pulse for one clock at the start of the second.
   assign instr_load_enable = p3_q & en_instr;
   assign addr_load_enable  = p3_q & en_addr;
   assign b_load_enable     = p3_q & en_b;
   assign d_load_enable     = p3_q & en_d;
   assign write_high_byte   = p2_q & en_write_high;
   assign write_low_byte    = p2_q & en_write_low;

   always_comb begin
      if (dest_sel == DSEL_READ_BUS) begin
         dest_mux = read_bus;
      end else if (dest_sel == DSEL_D_REG) begin
         dest_mux = d_q;
      end else if (dest_sel == DSEL_D_SHIFT) begin
         dest_mux = {1'b0, d_q[DATA_W-1:1]};
      end else begin
         dest_mux = sys_bus_data;
      end
   end
   assign data_display = dest_mux;

   // B takes the multiplexer output, so the selection must be held steady through the third phase.
   always_comb begin
      d_d = d_load_enable ? alu_out : d_q;
      b_d = b_load_enable ? dest_mux : b_q;
   end

   always_ff @(posedge clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         d_q <= D_RESET;
         b_q <= D_RESET;
      end else begin
         d_q <= d_d;
         b_q <= b_d;
      end
   end

   assign d_reg         = d_q;
   assign sys_bus_d_out = d_q;
   assign b_reg         = b_q;

endmodule

// [tb/mbcd_monitor.sv]
// Concurrent checks on the ports of the datapath slice.
`timescale 1ns/1ps
module mbcd_monitor
   import mbcd_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   rst_n,
   input wire logic [DATA_W-1:0]      scratch_rd_n,
   input wire logic [STATUS_W-1:0]    proc_status_reg_n,
   input wire logic [DATA_W-1:0]      aux_rd_n,
   input wire logic [DATA_W-1:0]      alu_a_input,
   input wire logic [BRANCH_W-1:0]    branch_test_field,
   input wire logic                   flag_load_cc,
   input wire logic [NEXT_ADDR_W-1:0] next_addr_field,
   input wire logic                   branch_taken,
   input wire logic [NEXT_ADDR_W-1:0] micro_pointer_next,
   input wire logic [MATCH_W-1:0]     buffered_micro_pointer,
   input wire logic [MATCH_W-1:0]     switch_register,
   input wire logic                   match,
   input wire logic                   phase_pulse_first,
   input wire logic                   phase_pulse_second,
   input wire logic                   phase_pulse_third,
   input wire logic                   cycle_length_bit0,
   input wire logic                   cycle_length_bit1,
   input wire logic                   restart,
   input wire logic                   maint_match_halt,
   input wire logic                   clock_halt_bit,
   input wire logic                   scope_sync,
   input wire logic                   clk_idle,
   input wire logic                   continue_run,
   input wire logic                   en_d,
   input wire logic                   d_load_enable,
   input wire logic [DATA_W-1:0]      alu_out,
   input wire logic [DATA_W-1:0]      d_reg,
   input wire logic [1:0]             dest_sel,
   input wire logic [DATA_W-1:0]      sys_bus_data,
   input wire logic [DATA_W-1:0]      dest_mux
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic mm_q;
   logic ch_q;
   logic held_q;
   logic held;
   // A match halt shows clk_idle just as the idle state does, so the halt is tracked here to tell them apart.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mm_q   <= 1'b0;
         ch_q   <= 1'b0;
         held_q <= 1'b0;
      end else begin
         mm_q   <= maint_match_halt;
         ch_q   <= clock_halt_bit;
         held_q <= held;
      end
   end
   assign held = clk_idle && (held_q || (scope_sync && mm_q && !ch_q));
   sequence short_start;
      phase_pulse_first && !cycle_length_bit1 && !cycle_length_bit0;
   endsequence
   sequence short_rest;
      ##2 phase_pulse_second ##2 phase_pulse_third;
   endsequence
   read_bus_a: assert property (alu_a_input == (~scratch_rd_n | {8'h00, ~proc_status_reg_n} | ~aux_rd_n))
      else $error("read bus value wrong");
   match_eq_a: assert property (match == (buffered_micro_pointer == switch_register))
      else $error("match flag wrong");
   flag_dec_a: assert property (flag_load_cc == (branch_test_field == BT_FLAG_CC))
      else $error("flag decode wrong");
   next_addr_a: assert property (micro_pointer_next == (next_addr_field | {7'h00, branch_taken}))
      else $error("next address wrong");
   d_gate_a: assert property (d_load_enable == (phase_pulse_third && en_d))
      else $error("D load gate wrong");
   d_load_a: assert property (d_load_enable |=> d_reg == $past(alu_out))
      else $error("D register did not load");
   dest_sel_a: assert property (dest_mux == (dest_sel == DSEL_D_REG ? d_reg : dest_sel == DSEL_D_SHIFT ?
      d_reg >> 1 : dest_sel == DSEL_SYS_BUS ? sys_bus_data : alu_a_input)) else $error("dest mux wrong");
   short_cycle_a: assert property (short_start |-> short_rest)
      else $error("short cycle phases wrong");
   start_run_a: assert property (clk_idle && restart && !held |-> ##[1:2] phase_pulse_first)
      else $error("restart did not start a cycle");
   halt_hold_a: assert property (held && !continue_run |=> !phase_pulse_first)
      else $error("clock left a match halt without continue");
endmodule
bind mbcd_top mbcd_monitor mbcd_monitor_inst (.*);

// [tb/mbcd_far_model.sv]
// ALU and system bus stand-in at the far side of the datapath.
`timescale 1ns/1ps
module mbcd_far_model
   import mbcd_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [DATA_W-1:0] alu_a_input,
   output logic      [DATA_W-1:0] alu_out,
   output logic      [DATA_W-1:0] sys_bus_data
);
   logic [DATA_W-1:0] bus_q = 16'h5a3c;
   logic [DATA_W-1:0] bus_d;
   // An incrementing ALU makes each D load differ from the read bus; the bus word changes every cycle.
   always_comb begin
      alu_out = alu_a_input + 16'h0001;
      bus_d   = ~bus_q ^ 16'h0101;
   end
   always_ff @(posedge clk) begin
      bus_q <= bus_d;
   end
   assign sys_bus_data = bus_q;
endmodule

// [tb/tb_mbcd_top.sv]
// Self-checking bench for the microbranch and clock datapath slice.
`timescale 1ns/1ps
module tb_mbcd_top;
   import mbcd_pkg::*;
   logic clk = 1'b0;
   logic rst_n;
   logic [DATA_W-1:0] scratch_rd_n, aux_rd_n, instr_reg, alu_out, sys_bus_data;
   logic [DATA_W-1:0] alu_a_input, addr_mux_rd, dest_mux, data_display, b_reg, d_reg, sys_bus_d_out;
   logic [7:0] proc_status_reg_n, branch_ctrl, instr_decode, machine_flags;
   logic [NEXT_ADDR_W-1:0] next_addr_field, micro_pointer_next;
   logic [MATCH_W-1:0] buffered_micro_pointer, switch_register;
   logic [BRANCH_W-1:0] branch_test_field;
   logic [1:0] dest_sel;
   logic maint_match_halt, clock_halt_bit, cycle_length_bit0, cycle_length_bit1, restart, continue_run;
   logic en_instr, en_addr, en_b, en_d, en_write_high, en_write_low;
   logic flag_load_cc, flag_clear, branch_taken, match, scope_sync, clk_run, clk_idle;
   logic phase_pulse_first, phase_pulse_second, phase_pulse_third, recycle_pulse;
   logic instr_load_enable, addr_load_enable, b_load_enable, d_load_enable, write_high_byte, write_low_byte;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   wire [3:0] ph = {phase_pulse_third, phase_pulse_second, phase_pulse_first, recycle_pulse};
   mbcd_top mbcd_top_inst (.*);
   mbcd_far_model mbcd_far_model_inst (.clk(clk), .alu_a_input(alu_a_input), .alu_out(alu_out),
      .sys_bus_data(sys_bus_data));
   always #20 clk = ~clk;
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Counts falling edges until the chosen pulse shows; 0 recycle, 1 to 3 the phases.
   task automatic wait_p(input int w, output int n);
      n = 0;
      while (ph[w] !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (n == 20) begin
         num_errors++;
         $display("Error at %0t: pulse wait timed out", $time);
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         $display("Error at %0t: run exceeded its cycle limit", $time);
         tally_and_finish();
      end
   end
   initial begin
      int n;
      int len;
      logic [15:0] de;
      logic [15:0] be;
      logic [15:0] xe;
      logic seen;
      {rst_n, maint_match_halt, clock_halt_bit, restart, continue_run, cycle_length_bit1, cycle_length_bit0} = '0;
      {en_instr, en_addr, en_b, en_d, en_write_high, en_write_low, dest_sel, branch_test_field} = '0;
      {branch_ctrl, machine_flags, instr_decode, instr_reg, next_addr_field} = '0;
      {buffered_micro_pointer, switch_register} = '0;
      {scratch_rd_n, aux_rd_n, proc_status_reg_n} = '1;
      de = D_RESET;
      be = D_RESET;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk({clk_run, clk_idle, d_reg, b_reg}, {2'b01, de, be});
      for (int k = 0; k < 3; k++) begin
         scratch_rd_n = ~(16'h0001 << (k * 5));
         proc_status_reg_n = ~(8'h80 >> k);
         aux_rd_n = ~(16'h8000 >> k);
         @(negedge clk);
         chk({alu_a_input, addr_mux_rd}, {2{~scratch_rd_n | {8'h00, ~proc_status_reg_n} | ~aux_rd_n}});
      end
      buffered_micro_pointer = 9'h1a5;
      switch_register = 9'h1a5;
      @(negedge clk);
      chk(match, 1'b1);
      switch_register = 9'h0a5;
      @(negedge clk);
      chk(match, 1'b0);
      next_addr_field = 8'h40;
      for (int k = 0; k < 8; k++) begin
         instr_reg = 16'h0001 << k;
         instr_decode = 8'h01 << k;
         branch_test_field = BT_INSTR_LO + 5'(k);
         @(negedge clk);
         chk({branch_taken, micro_pointer_next}, {1'b1, 8'h41});
         branch_test_field = BT_DECODE_LO + 5'(k);
         @(negedge clk);
         chk({branch_taken, micro_pointer_next}, {1'b1, 8'h41});
         instr_decode = 8'h00;
         @(negedge clk);
         chk({branch_taken, micro_pointer_next}, {1'b0, 8'h40});
         machine_flags = 8'h01 << k;
         branch_test_field = BT_DECODE_HI + 5'h01 + 5'(k);
         @(negedge clk);
         chk({branch_taken, micro_pointer_next}, {1'b1, 8'h41});
         branch_ctrl = 8'h01 << k;
         branch_test_field = (k == 0) ? BT_NONE : BT_CTRL_LO + 5'(k - 1);
         @(negedge clk);
         chk(branch_taken, k != 0);
      end
      branch_test_field = BT_FLAG_CC;
      @(negedge clk);
      chk({flag_load_cc, flag_clear}, 2'b10);
      branch_test_field = BT_FLAG_CLR;
      @(negedge clk);
      chk({flag_load_cc, flag_clear}, 2'b01);
      {branch_test_field, proc_status_reg_n, aux_rd_n} = {BT_NONE, 8'hff, 16'hffff};
      {dest_sel, clock_halt_bit} = {DSEL_D_SHIFT, 1'b1};
      for (int k = 0; k < 4; k++) begin
         len = (k == 0) ? 2 : (k == 1) ? 3 : 4;
         scratch_rd_n = ~(16'h1230 + 16'(k));
         {cycle_length_bit1, cycle_length_bit0} = 2'(k);
         {en_instr, en_addr, en_b, en_d, en_write_high, en_write_low} = k[0] ? 6'h15 : 6'h3f;
         restart = 1'b1;
         @(negedge clk);
         restart = 1'b0;
         wait_p(1, n);
         wait_p(2, n);
         chk(n, len);
         chk({write_high_byte, write_low_byte, instr_load_enable, addr_load_enable, b_load_enable, d_load_enable},
             {en_write_high, en_write_low, 4'h0});
         wait_p(3, n);
         chk(n, len);
         chk({write_high_byte, write_low_byte, instr_load_enable, addr_load_enable, b_load_enable, d_load_enable},
             {2'b00, en_instr, en_addr, en_b, en_d});
         if (en_b) be = de >> 1;
         de = 16'h1231 + 16'(k);
         @(negedge clk);
         chk({d_reg, sys_bus_d_out, b_reg}, {de, de, be});
         repeat (len + 1) @(negedge clk);
         chk({clk_run, clk_idle, phase_pulse_first}, 3'b010);
      end
      for (int s = 0; s < 4; s++) begin
         dest_sel = 2'(s);
         @(negedge clk);
         xe = s == 0 ? 16'h1233 : s == 1 ? de : s == 2 ? de >> 1 : sys_bus_data;
         chk({dest_mux, data_display}, {xe, xe});
      end
      {cycle_length_bit1, cycle_length_bit0, clock_halt_bit, maint_match_halt} = 4'h1;
      restart = 1'b1;
      @(negedge clk);
      restart = 1'b0;
      wait_p(1, n);
      wait_p(0, n);
      chk(n, 6);
      switch_register = 9'h1a5;
      seen = 1'b0;
      wait_p(3, n);
      restart = 1'b1;
      len = 0;
      repeat (12) begin
         @(negedge clk);
         seen = seen | scope_sync;
         len = len + int'(phase_pulse_first);
      end
      chk({seen, len[3:0]}, {1'b1, 4'h0});
      {restart, switch_register, clock_halt_bit, continue_run} = {1'b0, 9'h0a5, 2'b11};
      @(negedge clk);
      continue_run = 1'b0;
      wait_p(1, n);
      chk(phase_pulse_first, 1'b1);
      repeat (20) @(negedge clk);
      chk({clk_run, clk_idle}, 2'b01);
      tally_and_finish();
   end
endmodule
